// ===== src/scr_regs.sv
// system configuration and watchdog control registers
`timescale 1ns/1ps
module scr_regs (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic [15:0] ad_pins,
  input  wire logic        hw_irq,
  input  wire logic        pll_clk_phase,
  output logic             intc_slave_sel,
  output logic             block_in_memory_sel,
  output logic      [19:0] block_base,
  output logic             rx_enable_sel_1,
  output logic             rts_sel_1,
  output logic             rx_enable_sel_0,
  output logic             rts_sel_0,
  output logic             lower_region_narrow,
  output logic             middle_region_narrow,
  output logic             io_space_narrow,
  output logic             power_save_on,
  output logic             core_clk_en,
  output logic             whole_mid_select,
  output logic             strobe_style_sel,
  output logic             pulse_demod_on,
  output logic             clk_a_out,
  output logic             clk_b_out,
  output logic             wdt_reset,
  output logic             wdt_nmi
);
  import scr_pkg::*;

  logic [15:0] reloc_q;
  logic [15:0] sys_q;
  logic [15:0] aux_q;
  logic [15:0] wdt_q;
  logic [15:0] snap_q;
  logic [15:0] pin_s1_q;
  logic [15:0] pin_s2_q;
  logic        snap_done_q;
  logic [6:0]  div_cnt_q;
  logic        div_tick;
  logic [26:0] wdt_cnt_q;
  logic [4:0]  wdt_exp;
  logic        wdt_timeout;
  logic        wdt_reset_q;
  logic        wdt_nmi_q;
  logic [15:0] rdata_q;
  logic        wr_wdt;
  logic [15:0] wdt_w;

  // pins pass two flops before capture; no reset here, so the
  // levels seen while reset is low are still held at release
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      pin_s1_q <= ad_pins;
      pin_s2_q <= pin_s1_q;
    end
  end

  // capture once after release; reset can only load constants
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      snap_q      <= 16'h0000;
      snap_done_q <= 1'b0;
    end else if (clk_en && !snap_done_q) begin
      snap_q      <= pin_s2_q;
      snap_done_q <= 1'b1;
    end
  end

  // relocation register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reloc_q <= RST_RELOC;
    end else if (clk_en && reg_wr && reg_addr == OFS_RELOC) begin
      reloc_q <= reg_wdata & MASK_RELOC;
    end
  end

  // auxiliary register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aux_q <= RST_AUX;
    end else if (clk_en && reg_wr && reg_addr == OFS_AUX) begin
      aux_q <= reg_wdata & MASK_AUX;
    end
  end

  // system config; interrupt clear wins over a same-cycle write
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_q <= RST_SYS;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == OFS_SYS) begin
        sys_q <= reg_wdata & MASK_SYS;
      end
      if (hw_irq) begin
        sys_q[B_PSAVE] <= 1'b0;
      end
    end
  end

  // watchdog control; flags: hardware set beats software clear
  assign wr_wdt = reg_wr && reg_addr == OFS_WDT;
  always_comb begin
    wdt_w = wdt_q;
    if (wr_wdt) begin
      wdt_w = (reg_wdata & MASK_WDT & ~16'h3000) | (wdt_q & 16'h3000);
      wdt_w[B_WTO]  = wdt_q[B_WTO] & reg_wdata[B_WTO];
      wdt_w[B_WNMI] = wdt_q[B_WNMI] & reg_wdata[B_WNMI];
    end
    if (wdt_timeout) begin
      wdt_w[B_WTO] = 1'b1;
      if (!wdt_q[B_TIMEOUT_RESETS] && !wdt_q[B_WNMI]) begin
        wdt_w[B_WNMI] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_q <= RST_WDT;
    end else if (clk_en) begin
      wdt_q <= wdt_w;
    end
  end

  // lowest set count bit picks the exponent
  always_comb begin
    wdt_exp = 5'd0;
    for (int i = 7; i >= 1; i--) begin
      if (wdt_q[i]) begin
        wdt_exp = 5'(EXP_BIT1 + i - 1);
      end
    end
    if (wdt_q[0]) begin
      wdt_exp = 5'(EXP_BIT0);
    end
  end

  // timeout when counter reaches 2^exp - 1; zero field never fires
  assign wdt_timeout = wdt_q[B_WON] && (wdt_q[7:0] != 8'h00) &&
                       (wdt_cnt_q == 27'((28'h0000001 << wdt_exp) - 28'h0000001));

  // any write to the control register restarts the count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_cnt_q <= 27'h0000000;
    end else if (clk_en) begin
      if (!wdt_q[B_WON] || wr_wdt || wdt_timeout) begin
        wdt_cnt_q <= 27'h0000000;
      end else begin
        wdt_cnt_q <= wdt_cnt_q + 27'h0000001;
      end
    end
  end

  // one-cycle reset or nmi pulse on timeout
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_reset_q <= 1'b0;
      wdt_nmi_q   <= 1'b0;
    end else if (clk_en) begin
      wdt_reset_q <= wdt_timeout && (wdt_q[B_TIMEOUT_RESETS] || wdt_q[B_WNMI]);
      wdt_nmi_q   <= wdt_timeout && !wdt_q[B_TIMEOUT_RESETS] && !wdt_q[B_WNMI];
    end
  end
  assign wdt_reset = wdt_reset_q;
  assign wdt_nmi   = wdt_nmi_q;

  // power-save divider: tick once per 2^field cycles
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_q <= 7'h00;
    end else if (clk_en) begin
      if (div_tick) begin
        div_cnt_q <= 7'h00;
      end else begin
        div_cnt_q <= div_cnt_q + 7'h01;
      end
    end
  end
  assign div_tick = !sys_q[B_PSAVE] ||
                    (div_cnt_q == 7'((8'h01 << sys_q[2:0]) - 8'h01));
  assign core_clk_en = div_tick;

  // clock outputs: divided phase uses divider msb; low hold overrides
  logic div_phase;
  assign div_phase = sys_q[B_PSAVE] ? ((sys_q[2:0] == 3'h0) ? pll_clk_phase
                                       : div_cnt_q[sys_q[2:0] - 3'h1])
                                    : pll_clk_phase;
  assign clk_a_out = !sys_q[B_CALOW] &&
                     (sys_q[B_CASRC] ? pll_clk_phase : div_phase);
  assign clk_b_out = !sys_q[B_CBLOW] &&
                     (sys_q[B_CBSRC] ? pll_clk_phase : div_phase);

  // register field outputs
  assign intc_slave_sel       = reloc_q[B_SLAVE];
  assign block_in_memory_sel  = reloc_q[B_INMEM];
  assign block_base           = {reloc_q[B_INMEM] ? 4'h0 : reloc_q[11:8],
                                 reloc_q[7:0], 8'h00};
  assign rx_enable_sel_1      = aux_q[6];
  assign rts_sel_1            = aux_q[5];
  assign rx_enable_sel_0      = aux_q[4];
  assign rts_sel_0            = aux_q[3];
  assign lower_region_narrow  = aux_q[2];
  assign middle_region_narrow = aux_q[1];
  assign io_space_narrow      = aux_q[0];
  assign power_save_on        = sys_q[B_PSAVE];
  assign whole_mid_select     = sys_q[B_WHOLEMID];
  assign strobe_style_sel     = sys_q[B_STROBE];
  assign pulse_demod_on       = sys_q[B_DEMOD];

  // registered read data, unmapped reads zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 16'h0000;
    end else if (clk_en && reg_rd) begin
      unique case (reg_addr)
        OFS_RELOC: rdata_q <= reloc_q;
        OFS_RPC:   rdata_q <= snap_q;
        OFS_REL:   rdata_q <= {RELEASE_CODE, 8'h00};
        OFS_AUX:   rdata_q <= aux_q;
        OFS_SYS:   rdata_q <= sys_q;
        OFS_WDT:   rdata_q <= wdt_q;
        default:   rdata_q <= 16'h0000;
      endcase
    end
  end
  assign reg_rdata = rdata_q;
endmodule : scr_regs

// ===== common/scr_pkg.sv
// constants for the system configuration register bank
package scr_pkg;
  localparam logic [7:0]  OFS_WDT     = 8'hE6;
  localparam logic [7:0]  OFS_SYS     = 8'hF0;
  localparam logic [7:0]  OFS_AUX     = 8'hF2;
  localparam logic [7:0]  OFS_REL     = 8'hF4;
  localparam logic [7:0]  OFS_RPC     = 8'hF6;
  localparam logic [7:0]  OFS_RELOC   = 8'hFE;
  localparam logic [15:0] RST_RELOC   = 16'h20FF;
  localparam logic [15:0] RST_SYS     = 16'h0000;
  localparam logic [15:0] RST_AUX     = 16'h0000;
  localparam logic [15:0] RST_WDT     = 16'hC080;
  localparam logic [15:0] MASK_RELOC  = 16'h5FFF;
  localparam logic [15:0] MASK_SYS    = 16'hFF07;
  localparam logic [15:0] MASK_AUX    = 16'h007F;
  localparam logic [15:0] MASK_WDT    = 16'hC8FF;
  // release code value is arbitrary
  localparam logic [7:0]  RELEASE_CODE = 8'h5A;
  localparam int          B_SLAVE     = 14;
  localparam int          B_INMEM     = 12;
  localparam int          B_PSAVE     = 15;
  localparam int          B_WHOLEMID  = 14;
  localparam int          B_STROBE    = 13;
  localparam int          B_DEMOD     = 12;
  localparam int          B_CBSRC     = 11;
  localparam int          B_CBLOW     = 10;
  localparam int          B_CASRC     = 9;
  localparam int          B_CALOW     = 8;
  localparam int          B_WON       = 15;
  localparam int          B_TIMEOUT_RESETS      = 14;
  localparam int          B_WTO       = 13;
  localparam int          B_WNMI      = 12;
  localparam int          EXP_BIT0    = 10;
  localparam int          EXP_BIT1    = 20;
endpackage : scr_pkg

// ===== tb/scr_regs_properties.sv
// port assertions for the configuration register bank
`timescale 1ns/1ps
module scr_regs_properties
  import scr_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        clk_en,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        hw_irq,
  input wire logic        block_in_memory_sel,
  input wire logic [19:0] block_base,
  input wire logic        power_save_on,
  input wire logic        wdt_reset,
  input wire logic        wdt_nmi
);
  logic nmi_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence rd_of(logic [7:0] a);
    clk_en && reg_rd && reg_addr == a;
  endsequence
  // nmi seen and not yet cleared by a zero write
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) nmi_q <= 1'b0;
    else if (wdt_nmi) nmi_q <= 1'b1;
    else if (clk_en && reg_wr && reg_addr == OFS_WDT && !reg_wdata[B_WNMI]) nmi_q <= 1'b0;
  end
  rel_read_a: assert property (rd_of(OFS_REL) |=> reg_rdata == {RELEASE_CODE, 8'h00})
    else $error("bad release read");
  sys_reserved_a: assert property (rd_of(OFS_SYS) |=> reg_rdata[7:3] == 5'h00)
    else $error("reserved bits set");
  base_low_a: assert property (block_base[7:0] == 8'h00)
    else $error("base low bits set");
  mem_base_a: assert property (block_in_memory_sel |-> block_base[19:16] == 4'h0)
    else $error("memory base too high");
  irq_clear_a: assert property (clk_en && hw_irq |=> !power_save_on)
    else $error("power save kept");
  rdata_hold_a: assert property (!(clk_en && reg_rd) |=> $stable(reg_rdata))
    else $error("read data moved");
  reset_excl_a: assert property (wdt_reset |-> !wdt_nmi [*2])
    else $error("nmi beside reset");
  second_nmi_a: assert property (nmi_q |-> !wdt_nmi)
    else $error("second nmi");
endmodule : scr_regs_properties

// ===== tb/scr_core_model.sv
// processor core model issuing register reads and writes
`timescale 1ns/1ps
module scr_core_model
  import scr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [15:0] reg_rdata,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [7:0]  reg_addr,
  output logic      [15:0] reg_wdata
);
  // idle bus
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end
  // one write; test bit always sent as zero
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = (a == OFS_WDT) ? (d & 16'hF7FF) : d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask : wr
  // one read; data settled after the request edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
endmodule : scr_core_model

// ===== tb/scr_regs_tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module scr_regs_tb;
  import scr_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, hw_irq = 1'b0, pll_clk_phase = 1'b0;
  logic [15:0] ad_pins = 16'hA5C3, reg_wdata, reg_rdata, d;
  logic [7:0] reg_addr;
  logic [19:0] block_base;
  logic reg_wr, reg_rd, intc_slave_sel, block_in_memory_sel, rx_enable_sel_1, rts_sel_1;
  logic rx_enable_sel_0, rts_sel_0, lower_region_narrow, middle_region_narrow, io_space_narrow;
  logic power_save_on, core_clk_en, whole_mid_select, strobe_style_sel, pulse_demod_on;
  logic clk_a_out, clk_b_out, wdt_reset, wdt_nmi;
  int failures = 0;
  int comparisons = 0;
  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;
  scr_regs DUT (.sys_clk, .arst_n, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .ad_pins, .hw_irq, .pll_clk_phase, .intc_slave_sel, .block_in_memory_sel, .block_base,
    .rx_enable_sel_1, .rts_sel_1, .rx_enable_sel_0, .rts_sel_0, .lower_region_narrow,
    .middle_region_narrow, .io_space_narrow, .power_save_on, .core_clk_en, .whole_mid_select,
    .strobe_style_sel, .pulse_demod_on, .clk_a_out, .clk_b_out, .wdt_reset, .wdt_nmi);
  scr_core_model core (.sys_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  task automatic conclude;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    core.rd(a, d);
    chk(d, exp);
  endtask : rchk
  // bounded wait for a watchdog pulse; n counts cycles waited
  task automatic wait_pulse(input bit nmi, output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while ((nmi ? wdt_nmi : wdt_reset) !== 1'b1 && n < 1100);
    if (n >= 1100) begin
      failures++;
      conclude();
    end
  endtask : wait_pulse
  task automatic t_reset;
    rchk(OFS_RELOC, 16'h20FF);
    rchk(OFS_SYS, 16'h0000);
    rchk(OFS_AUX, 16'h0000);
    rchk(OFS_WDT, 16'hC080);
    rchk(8'h80, 16'h0000);
  endtask : t_reset
  task automatic t_reloc;
    core.wr(OFS_RELOC, 16'h5ABC);
    chk({2'b00, intc_slave_sel, block_in_memory_sel, block_base[19:8]}, 16'h30BC);
    core.wr(OFS_RELOC, 16'h0ABC);
    chk({2'b00, intc_slave_sel, block_in_memory_sel, block_base[19:8]}, 16'h0ABC);
    core.wr(OFS_REL, 16'hFFFF);
    rchk(OFS_REL, {RELEASE_CODE, 8'h00});
  endtask : t_reloc
  task automatic t_aux;
    logic [15:0] v[2] = '{16'hFFFF, 16'h0055};
    foreach (v[i]) begin
      core.wr(OFS_AUX, v[i]);
      chk({9'h000, rx_enable_sel_1, rts_sel_1, rx_enable_sel_0, rts_sel_0, lower_region_narrow,
        middle_region_narrow, io_space_narrow}, v[i] & 16'h007F);
    end
  endtask : t_aux
  task automatic t_sys;
    core.wr(OFS_SYS, 16'h7FFF);
    rchk(OFS_SYS, 16'h7F07);
    chk({13'h0000, whole_mid_select, strobe_style_sel, pulse_demod_on}, 16'h0007);
    core.wr(OFS_SYS, 16'h6A00);
    chk({13'h0000, whole_mid_select, strobe_style_sel, pulse_demod_on}, 16'h0006);
    for (int l = 0; l < 2; l++) begin
      @(negedge sys_clk);
      pll_clk_phase = l[0];
      #1 chk({14'h0000, clk_a_out, clk_b_out}, {14'h0000, l[0], l[0]});
    end
    core.wr(OFS_SYS, 16'h6F00);
    chk({14'h0000, clk_a_out, clk_b_out}, 16'h0000);
  endtask : t_sys
  // divided clock enable counted over whole periods, then an interrupt ends power save
  task automatic t_save;
    int n;
    for (int f = 0; f < 8; f += 3) begin
      core.wr(OFS_SYS, 16'h8000 | 16'(f));
      n = 0;
      repeat (128) begin
        @(negedge sys_clk);
        n += int'(core_clk_en === 1'b1);
      end
      chk(n[15:0], 16'(128 >> f));
      hw_irq = 1'b1;
      @(negedge sys_clk);
      hw_irq = 1'b0;
      chk({15'h0000, power_save_on}, 16'h0000);
    end
    rchk(OFS_SYS, 16'h0006);
  endtask : t_save
  task automatic t_wdt;
    int n;
    core.wr(OFS_WDT, 16'hC801);
    wait_pulse(1'b0, n);
    wait_pulse(1'b0, n);
    chk(n[15:0], 16'h0400);
    rchk(OFS_WDT, 16'hE001);
    core.wr(OFS_WDT, 16'h8001);
    wait_pulse(1'b1, n);
    wait_pulse(1'b0, n);
    chk(n[15:0], 16'h0400);
    rchk(OFS_WDT, 16'hB001);
    core.wr(OFS_WDT, 16'hB000);
    rchk(OFS_WDT, 16'hB000);
    core.wr(OFS_WDT, 16'h0000);
    rchk(OFS_WDT, 16'h0000);
  endtask : t_wdt
  // second reset with pins held steady around the release
  task automatic t_snap;
    ad_pins = 16'h3C96;
    repeat (4) @(negedge sys_clk);
    arst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    ad_pins = 16'hC369;
    rchk(OFS_RPC, 16'h3C96);
    rchk(OFS_RELOC, 16'h20FF);
    rchk(OFS_WDT, 16'hC080);
  endtask : t_snap
  initial begin
    repeat (2) @(negedge sys_clk);
    arst_n = 1'b1;
    t_reset();
    t_reloc();
    t_aux();
    t_sys();
    t_save();
    t_wdt();
    t_snap();
    conclude();
  end
endmodule : scr_regs_tb
bind scr_regs scr_regs_properties props (.sys_clk, .arst_n, .clk_en, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .hw_irq, .block_in_memory_sel, .block_base, .power_save_on,
  .wdt_reset, .wdt_nmi);
